// file: hdl/psc_control.v
/*
 * Control and status signalling of a redundant supply module:
 * on-request sequencing, power-good, fault alert and presence.
 * Assumes analog monitors deliver levels synchronous to sys_clk;
 * the management bus target sits in another block.
 */
`timescale 1ns/1ps
`include "psc_defines.vh"

module psc_control #(
    parameter [15:0] MS_CYCLES = `PSC_MS_CYCLES
) (
    input  wire sys_clk,
    input  wire srst,
    input  wire power_on_request_n,
    input  wire outputs_in_reg,
    input  wire current_limit,
    input  wire input_lost,
    input  wire temp_warning,
    input  wire general_failure,
    input  wire over_current,
    input  wire over_voltage,
    input  wire under_voltage,
    input  wire fan_failure,
    input  wire end_of_life,
    input  wire env_exceeded,
    input  wire protect_trip,
    output reg  main_enable,
    output reg  power_good,
    output reg  fault_alert_n_out,
    output reg  fault_alert_n_oe,
    output reg  amber_led,
    output reg  latched_off,
    output reg  module_installed_n
);
    // Millisecond enable
    wire                 ms_tick;
    // Filtered on request
    wire                 req_on;
    // Sequencer state
    reg  [2:0]           state;
    reg  [2:0]           next_state;
    // Millisecond timer for sequencing
    reg  [`PSC_MS_W-1:0] tmr;
    // Time power-good has been low
    reg  [`PSC_MS_W-1:0] low_ms;
    // Time request has been released
    reg  [`PSC_MS_W-1:0] rel_ms;
    // Release lasted long enough to clear
    reg                  clr_armed;
    // Combined alert cause: any of the eight fault levels (from monitors)
    wire                 alert_cause;

    // Behaviour notes for the next engineer
    // no bus logic here; target lives elsewhere
    // The management bus target is a separate block.
    // Nothing here talks on that bus or times it.
    //
    // Timebase
    // All delays count millisecond ticks from the divider.
    // MS_CYCLES sets cycles per tick; it stays at the
    // full clock rate in the product and is only made
    // smaller by a bench to shorten long waits.
    // A count of N ticks lasts between N-1 and N ms,
    // since a state may be entered just before a tick.
    // Every chosen delay therefore keeps a margin of
    // more than one tick from its window bound.
    //
    // Request path
    // The pin passes the synchroniser and the debouncer
    // before the sequencer sees it. Glitches shorter
    // than the debounce never reach the timers, at the
    // price of a few ms extra latency in both directions.
    // That latency stays well under the 5 ms off limit.
    //
    // Sequencer
    // Off: waits for a request, a clear latch and a
    //      served power-good low time.
    // Ramp: main rail enabled, waits for the chosen
    //       turn-on delay and for regulation.
    // Wait good: counts the power-good delay; current
    //            limit restarts that count from zero.
    // On: power-good high until release, trip, loss of
    //     regulation or loss of input.
    // Any abort returns to off; outputs follow the next
    // state, so they drop on the same edge as the state.
    //
    // Latch-off
    // A trip latches the main rail off. Only a filtered
    // release of at least one second followed by a new
    // request, or srst, clears it; a shorter release leaves it set.
    // A trip in the clearing cycle wins over the clear.
    //
    // Alert
    // The alert pin is open drain: data is always low and
    // only the enable moves. The amber indicator is made
    // from the very same term, so the two never differ by
    // even one cycle.
    //
    // Presence
    // The installed indication is a constant low level;
    // it is registered only so every output is a flop.
    //
    // Hazards
    // Monitor levels are taken as already synchronous.
    // A monitor on another clock must be synchronised
    // before it reaches these ports.
    // The sequencer timer saturates, so a stuck ramp
    // never wraps round into a false early transition.

    // Timebase
    psc_ms_tick #(
        .MS_CYCLES (MS_CYCLES)
    ) u_tick (
        .sys_clk (sys_clk),
        .srst    (srst),
        .ms_tick (ms_tick)
    );

    psc_req_filter u_req (
        .sys_clk (sys_clk),
        .srst    (srst),
        .ms_tick (ms_tick),
        .pin_n   (power_on_request_n),
        .req_on  (req_on)
    );

    // Fault detection as one decode
    function alert_any;
        input t, g, oc, ov, uv, fan, eol, env;
        begin
            alert_any = t | g | oc | ov | uv | fan | eol | env;
        end
    endfunction

    assign alert_cause = alert_any(temp_warning, general_failure, over_current,
                                   over_voltage, under_voltage, fan_failure,
                                   end_of_life, env_exceeded);

    // Next state of the sequencer
    always @* begin
        next_state = state;
        case (state)
            `PSC_ST_OFF: begin
                // hold off until low time served
                if (req_on && !latched_off && low_ms >= `PSC_GOOD_LOW_MS)
                    next_state = `PSC_ST_RAMP;
            end
            `PSC_ST_RAMP: begin
                if (!req_on || protect_trip)
                    next_state = `PSC_ST_OFF;
                else if (tmr >= `PSC_ON_DLY_MS && outputs_in_reg)
                    next_state = `PSC_ST_WAIT_GOOD;
            end
            `PSC_ST_WAIT_GOOD: begin
                if (!req_on || protect_trip || !outputs_in_reg || input_lost)
                    next_state = `PSC_ST_OFF;
                else if (tmr >= `PSC_GOOD_DLY_MS)
                    next_state = `PSC_ST_ON;
            end
            `PSC_ST_ON: begin
                if (!req_on || protect_trip || !outputs_in_reg || input_lost)
                    next_state = `PSC_ST_OFF;
            end
            default: next_state = `PSC_ST_OFF;
        endcase
    end

    // Sequencer state and timer
    always @(posedge sys_clk) begin
        if (srst) begin
            state <= `PSC_ST_OFF;
            tmr   <= {`PSC_MS_W{1'b0}};
        end else begin
            state <= next_state;
            if (next_state != state)
                tmr <= {`PSC_MS_W{1'b0}};
            else if (state == `PSC_ST_WAIT_GOOD && current_limit)
                tmr <= {`PSC_MS_W{1'b0}};
            else if (ms_tick && tmr != `PSC_ON_MAX_MS + `PSC_GOOD_MAX_MS)
                tmr <= tmr + 16'h0001;
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            low_ms <= `PSC_GOOD_LOW_MS;
        end else if (power_good) begin
            low_ms <= {`PSC_MS_W{1'b0}};
        end else if (ms_tick && low_ms < `PSC_GOOD_LOW_MS) begin
            low_ms <= low_ms + 16'h0001;
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            latched_off <= 1'b0;
            rel_ms      <= {`PSC_MS_W{1'b0}};
            clr_armed   <= 1'b0;
        end else begin
            if (req_on) begin
                rel_ms <= {`PSC_MS_W{1'b0}};
            end else if (ms_tick && rel_ms < `PSC_CLR_HOLD_MS) begin
                rel_ms <= rel_ms + 16'h0001;
            end
            if (!req_on && rel_ms >= `PSC_CLR_HOLD_MS)
                clr_armed <= 1'b1;
            // Trip wins over a clear in the same cycle
            if (protect_trip) begin
                latched_off <= 1'b1;
                clr_armed   <= 1'b0;
            end else if (req_on && clr_armed) begin
                latched_off <= 1'b0;
                clr_armed   <= 1'b0;
            end
        end
    end

    // Output registers
    always @(posedge sys_clk) begin
        if (srst) begin
            main_enable        <= 1'b0;
            power_good         <= 1'b0;
            fault_alert_n_out  <= 1'b0;
            fault_alert_n_oe   <= 1'b0;
            amber_led          <= 1'b0;
            module_installed_n <= 1'b0;
        end else begin
            main_enable <= (next_state == `PSC_ST_RAMP) ||
                           (next_state == `PSC_ST_WAIT_GOOD) ||
                           (next_state == `PSC_ST_ON);
            power_good <= (next_state == `PSC_ST_ON);
            // drive low on alert, else release
            // amber and alert from one term
            fault_alert_n_out <= 1'b0;
            fault_alert_n_oe  <= alert_cause | protect_trip | latched_off;
            amber_led         <= alert_cause | protect_trip | latched_off;
            module_installed_n <= 1'b0;
        end
    end
endmodule

// file: hdl/psc_defines.vh
/*
 * Shared constants of the supply control signalling logic.
 * Assumes a 50 MHz sys_clk; all times are derived from it.
 */
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH

// Clock rate in kHz
`define PSC_CLK_KHZ          50000
// Cycles in one millisecond
`define PSC_MS_CYCLES        (`PSC_CLK_KHZ)
// Millisecond counter width
`define PSC_MS_W             16
// Power-up delay window, ms
`define PSC_ON_MIN_MS        16'h0005
`define PSC_ON_MAX_MS        16'h0190
// Chosen turn-on delay, ms
`define PSC_ON_DLY_MS        16'h0014
// Turn-off and power-good drop limit, ms
`define PSC_OFF_MAX_MS       16'h0005
// Power-good delay window, ms
`define PSC_GOOD_MIN_MS      16'h0064
`define PSC_GOOD_MAX_MS      16'h01F4
// Chosen power-good delay, ms
`define PSC_GOOD_DLY_MS      16'h0096
// Least power-good low time, ms
`define PSC_GOOD_LOW_MS      16'h0064
// Latch clear hold time, ms (1 s)
`define PSC_CLR_HOLD_MS      16'h03E8
// Debounce length in ms ticks
`define PSC_DEB_MS           4'h2
// Sequencer states
`define PSC_ST_OFF           3'h0
`define PSC_ST_RAMP          3'h1
`define PSC_ST_WAIT_GOOD     3'h2
`define PSC_ST_ON            3'h3
`define PSC_ST_FAULT         3'h4

`endif

// file: hdl/psc_ms_tick.v
/*
 * Millisecond timebase: one-cycle enable pulse every millisecond.
 * Assumes the 50 MHz system clock and a synchronous reset.
 */
`timescale 1ns/1ps
`include "psc_defines.vh"

module psc_ms_tick #(
    parameter [15:0] MS_CYCLES = `PSC_MS_CYCLES
) (
    input  wire sys_clk,
    input  wire srst,
    output reg  ms_tick
);
    // Cycle counter within one millisecond
    reg [15:0] cnt;
    localparam [15:0] LAST = MS_CYCLES - 16'h0001;

    // Divider producing the tick
    always @(posedge sys_clk) begin
        if (srst) begin
            cnt     <= 16'h0000;
            ms_tick <= 1'b0;
        end else if (cnt == LAST) begin
            cnt     <= 16'h0000;
            ms_tick <= 1'b1;
        end else begin
            cnt     <= cnt + 16'h0001;
            ms_tick <= 1'b0;
        end
    end
endmodule

// file: hdl/psc_req_filter.v
/*
 * Synchroniser and debouncer for the active-low on-request pin.
 * Assumes an asynchronous pin and a millisecond enable pulse.
 */
`timescale 1ns/1ps
`include "psc_defines.vh"

module psc_req_filter (
    input  wire sys_clk,
    input  wire srst,
    input  wire ms_tick,
    input  wire pin_n,
    output reg  req_on
);
    // Three-stage synchroniser
    reg       s1;
    reg       s2;
    reg       s3;
    // Debounce counter
    reg [3:0] deb;

    // Sample chain, first stage read only by the second
    always @(posedge sys_clk) begin
        if (srst) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end else begin
            s1 <= pin_n;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            deb    <= 4'h0;
            req_on <= 1'b0;
        end else if ((s2 != s3) || (req_on == ~s3)) begin
            // Unsettled or unchanged: restart count
            deb <= 4'h0;
        end else if (ms_tick) begin
            if (deb == `PSC_DEB_MS) begin
                req_on <= ~s3;
                deb    <= 4'h0;
            end else begin
                deb <= deb + 4'h1;
            end
        end
    end
endmodule

// file: test/psc_control_assertions.sv
/* Checker on the control block ports.
   Assumes 50 MHz sys_clk and the synchronous srst. */
`timescale 1ns/1ps
module psc_chk #(
    parameter int MS = 50000
) (
    input wire sys_clk,
    input wire srst,
    input wire power_on_request_n,
    input wire outputs_in_reg,
    input wire input_lost,
    input wire temp_warning,
    input wire general_failure,
    input wire over_current,
    input wire over_voltage,
    input wire under_voltage,
    input wire fan_failure,
    input wire end_of_life,
    input wire env_exceeded,
    input wire protect_trip,
    input wire latched_off,
    input wire main_enable,
    input wire power_good,
    input wire fault_alert_n_oe,
    input wire amber_led,
    input wire module_installed_n
);
    localparam int GOOD_MIN = 100 * MS; // 100 ms of cycles
    localparam int OFF_MAX  = 5 * MS;   // 5 ms of cycles
    wire warn = temp_warning | general_failure | over_current | over_voltage
              | under_voltage | fan_failure;
    wire any_cause = warn | end_of_life | env_exceeded | protect_trip | latched_off;
    int reg_cnt; // Cycles in regulation
    int low_cnt; // Cycles power-good low
    int rel_cnt; // Cycles request pin released
    // Helper counters; low time starts satisfied
    always @(posedge sys_clk) begin
        reg_cnt <= (srst || !outputs_in_reg) ? 0 : reg_cnt + 1;
        low_cnt <= srst ? GOOD_MIN : (power_good ? 0 : low_cnt + 1);
        rel_cnt <= (srst || !power_on_request_n) ? 0 : rel_cnt + 1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    chk_alert_set: assert property (warn |=> fault_alert_n_oe)
        else $error("alert missing");
    chk_alert_clr: assert property (!any_cause |=> !fault_alert_n_oe)
        else $error("alert stuck");
    chk_amber_same: assert property (amber_led == fault_alert_n_oe)
        else $error("amber differs");
    chk_module_installed_n_low: assert property (!module_installed_n)
        else $error("presence high");
    chk_good_late: assert property ($rose(power_good) |-> reg_cnt >= GOOD_MIN)
        else $error("good early");
    chk_good_rest: assert property ($rose(power_good) |-> low_cnt >= GOOD_MIN)
        else $error("good low too short");
    chk_good_drop: assert property (!outputs_in_reg || input_lost |-> ##[1:2] !power_good)
        else $error("good held");
    chk_off_time: assert property (rel_cnt >= OFF_MAX |-> !main_enable && !power_good)
        else $error("off late");
    cover property ($rose(main_enable));
    cover property ($rose(fault_alert_n_oe));
    cover property (rel_cnt == OFF_MAX);
endmodule
bind psc_control psc_chk #(.MS(MS_CYCLES)) u_chk (.*);

// file: test/psc_control_bench.sv
/* Bench for the control block with the host model on the request pin.
   Assumes 50 MHz clock; the millisecond delays are waited out. */
`timescale 1ns/1ps
module psc_control_bench;
    localparam int MS = 50; // Shortened millisecond for the bench
    logic sys_clk = 0, srst = 1, want_on = 0, in_reg = 0, cur_lim = 0, lost = 0, trip = 0;
    logic [7:0] cause = 0; // Alert cause levels
    wire  pin_n, alert_n, me, pg, a_out, a_oe, amber, latch, inst_n;
    int   err_total = 0, num_checks = 0;
    // Cause pattern, expected alert in bit 8
    logic [8:0] rows [9] = '{9'h000, 9'h101, 9'h102, 9'h104, 9'h108,
                             9'h110, 9'h120, 9'h140, 9'h180};
    initial forever #10 sys_clk = ~sys_clk;
    psc_host host (.want_on(want_on), .alert_drv(a_oe), .alert_val(a_out),
        .request_pin_n(pin_n), .alert_wire_n(alert_n));
    psc_control #(.MS_CYCLES(MS)) DUT (.sys_clk(sys_clk), .srst(srst), .power_on_request_n(pin_n),
        .outputs_in_reg(in_reg), .current_limit(cur_lim), .input_lost(lost),
        .temp_warning(cause[0]), .general_failure(cause[1]), .over_current(cause[2]),
        .over_voltage(cause[3]), .under_voltage(cause[4]), .fan_failure(cause[5]),
        .end_of_life(cause[6]), .env_exceeded(cause[7]), .protect_trip(trip),
        .main_enable(me), .power_good(pg), .fault_alert_n_out(a_out),
        .fault_alert_n_oe(a_oe), .amber_led(amber), .latched_off(latch),
        .module_installed_n(inst_n));
    // One bit compare
    task automatic chk(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask
    // Bounded wait for main enable
    task automatic wait_me(input logic v, input int lim);
        for (int i = 0; i < lim && me !== v; i++) @(negedge sys_clk);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (95000) @(posedge sys_clk);
        err_total++;
        summarize;
    end
    // Main sequence
    initial begin
        repeat (6) @(negedge sys_clk);
        chk("main_enable", 0, me);
        chk("power_good", 0, pg);
        srst = 0;
        foreach (rows[k]) begin
            cause = rows[k][7:0];
            repeat (2) @(negedge sys_clk);
            chk("alert_pin", ~rows[k][8], alert_n);
            chk("amber_led", rows[k][8], amber);
            chk("installed_n", 0, inst_n);
        end
        cause = 8'h00;
        $display("alert table done");
        want_on = 1;
        repeat (90) @(negedge sys_clk);
        chk("main_enable", 0, me);
        wait_me(1, 110);
        chk("main_enable", 1, me);
        in_reg = 1;
        repeat (10) @(negedge sys_clk);
        chk("power_good", 0, pg);
        repeat (60 * MS) @(negedge sys_clk);
        cur_lim = 1;
        repeat (100 * MS) @(negedge sys_clk);
        chk("power_good", 0, pg);
        cur_lim = 0;
        repeat (120 * MS) @(negedge sys_clk);
        chk("power_good", 0, pg);
        repeat (50 * MS) @(negedge sys_clk);
        chk("power_good", 1, pg);
        want_on = 0;
        wait_me(0, 5 * MS);
        chk("main_enable", 0, me);
        chk("power_good", 0, pg);
        in_reg = 0;
        $display("on off done");
        want_on = 1;
        repeat (50 * MS) @(negedge sys_clk);
        chk("main_enable", 0, me);
        wait_me(1, 60 * MS);
        chk("main_enable", 1, me);
        trip = 1;
        @(negedge sys_clk);
        trip = 0;
        repeat (2) @(negedge sys_clk);
        chk("latched_off", 1, latch);
        chk("main_enable", 0, me);
        want_on = 0;
        repeat (1010 * MS) @(negedge sys_clk);
        chk("latched_off", 1, latch);
        want_on = 1;
        repeat (4 * MS) @(negedge sys_clk);
        chk("latched_off", 0, latch);
        chk("main_enable", 1, me);
        trip = 1;
        @(negedge sys_clk);
        trip = 0;
        @(negedge sys_clk);
        chk("latched_off", 1, latch);
        srst = 1;
        repeat (6) @(negedge sys_clk);
        srst = 0;
        @(negedge sys_clk);
        chk("latched_off", 0, latch);
        chk("main_enable", 0, me);
        $display("trip done");
        summarize;
    end
endmodule

// file: test/psc_host.sv
/* Host board controller model: open-drain request pin and alert line.
   Assumes pull-ups on both lines, as on the host board. */
`timescale 1ns/1ps
module psc_host (
    input  wire want_on,
    input  wire alert_drv,
    input  wire alert_val,
    output wire request_pin_n,
    output wire alert_wire_n
);
    // model issues no bus traffic, so speed and spacing hold
    // pin pulled low for on, pull-up high otherwise
    assign request_pin_n = want_on ? 1'b0 : 1'b1;
    // pull-up wins while the supply releases the line
    assign alert_wire_n = alert_drv ? alert_val : 1'b1;
endmodule
